// *** design/uop_top.sv ***
// usb otg status, pin control and power control with an ahb-lite register slave
`include "uop_defs.svh"
`default_nettype none
module uop_top #(
  parameter logic [`UOP_TMR_W-1:0] LSTABLE_CYCLES =
    `UOP_TMR_W'((`UOP_LSTABLE_NS + `UOP_CLK_NS - 1) / `UOP_CLK_NS),
  parameter logic [`UOP_TMR_W-1:0] IDLE_CYCLES    =
    `UOP_TMR_W'((`UOP_IDLE_NS + `UOP_CLK_NS - 1) / `UOP_CLK_NS)
) (
  // clock and reset
  input  wire logic              CLK_I,
  input  wire logic              RST_B_I,
  // ahb-lite slave
  input  wire logic              HSEL_I,
  input  wire uop_pkg::uop_word_t HADDR_I,
  input  wire logic [1:0]        HTRANS_I,
  input  wire logic              HWRITE_I,
  input  wire logic [2:0]        HSIZE_I,
  input  wire uop_pkg::uop_word_t HWDATA_I,
  input  wire logic              HREADY_I,
  output logic                   HREADYOUT_O,
  output logic                   HRESP_O,
  output uop_pkg::uop_word_t     HRDATA_O,
  // cable side levels, asynchronous
  input  wire logic              CABLE_IDENTITY_I,
  input  wire logic              VBUS_SESSION_VALID_I,
  input  wire logic              DPLUS_I,
  input  wire logic              DMINUS_I,
  // protocol engine events and hardware pull requests
  input  wire logic              STALL_EV_I,
  input  wire logic              ATTACH_EV_I,
  input  wire logic              TOKEN_DONE_EV_I,
  input  wire logic              FRAME_START_EV_I,
  input  wire logic              BUS_RESET_EV_I,
  input  wire uop_pkg::uop_byte_t ERROR_EV_I,
  input  wire logic [3:0]        HW_PULLS_I,
  input  wire logic              ACTIVITY_ACK_I,
  // pads and power control
  output logic                   DPLUS_PULLUP_O,
  output logic                   DMINUS_PULLUP_O,
  output logic                   DPLUS_PULLDOWN_O,
  output logic                   DMINUS_PULLDOWN_O,
  output logic                   VBUS_POWER_O,
  output logic                   VBUS_CHARGE_O,
  output logic                   VBUS_DISCHARGE_O,
  output logic                   USB_CLK_RUN_O,
  output logic                   XCVR_LOW_POWER_O,
  output logic                   ANALOG_ENABLE_O,
  output logic                   PINS_OWNED_O,
  output logic                   SLEEP_BLOCK_O,
  output logic                   TOKEN_FIFO_ADVANCE_O,
  output logic                   ACTIVITY_PENDING_O
);
  import uop_pkg::*;

  localparam logic [`UOP_TMR_W-1:0] RESUME_CYCLES =
    `UOP_TMR_W'((`UOP_RESUME_NS + `UOP_CLK_NS - 1) / `UOP_CLK_NS);
  localparam int unsigned N_SYNC = 4;

  // ---------------------------------------------------------------- pin synchronisers
  logic [N_SYNC-1:0] pin_raw;
  logic [N_SYNC-1:0] sync1_q;
  logic [N_SYNC-1:0] sync2_q;
  logic [N_SYNC-1:0] prev_q;

  assign pin_raw = {CABLE_IDENTITY_I, VBUS_SESSION_VALID_I, DPLUS_I, DMINUS_I};

  genvar gi;
  generate
    for (gi = 0; gi < N_SYNC; gi++) begin : g_sync
      always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
          prev_q[gi]  <= 1'b0;
        end else begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
          prev_q[gi]  <= sync2_q[gi];
        end
      end
    end
  endgenerate

  wire id_s   = sync2_q[3];
  wire vbus_s = sync2_q[2];
  wire dp_s   = sync2_q[1];
  wire dm_s   = sync2_q[0];

  // full-speed line states
  wire line_se0 = ~dp_s & ~dm_s;
  wire line_j   = dp_s & ~dm_s;
  wire line_k   = ~dp_s & dm_s;
  wire line_chg = (dp_s ^ prev_q[1]) | (dm_s ^ prev_q[0]);
  wire any_chg  = |(sync2_q ^ prev_q);

  // ---------------------------------------------------------------- registers
  logic [7:0]     otgcon_q;
  logic [7:0]     otgcon_d;
  logic [7:0]     pwrc_q;
  logic [7:0]     pwrc_d;
  logic [7:0]     irqf_q;
  logic [7:0]     irqf_d;
  logic [7:0]     errstat_q;
  logic [7:0]     errstat_d;
  logic [7:0]     erren_q;
  logic [7:0]     erren_d;
  logic           act_pend_q;
  logic           act_pend_d;
  logic           resume_hit_q;
  logic           idle_hit_q;
  logic           fifo_adv_q;
  logic [3:0]     drain_q;
  logic [3:0]     drain_d;
  uop_pwr_state_t pwr_q;
  uop_pwr_state_t pwr_d;

  wire enable_w  = pwrc_q[`UOP_PC_ENABLE];
  wire suspend_w = pwrc_q[`UOP_PC_SUSPEND];
  wire guard_w   = pwrc_q[`UOP_PC_SLPGRD];
  wire busy_w    = (pwr_q != UOP_PWR_OFF);

  // ---------------------------------------------------------------- ahb-lite slave
  logic       dph_wr_q;
  logic       dph_rd_q;
  logic [7:0] dph_addr_q;
  uop_word_t  rdata_q;

  wire addr_take = HSEL_I & HREADY_I & HTRANS_I[1];
  wire wr_now    = dph_wr_q;
  wire [7:0] wbyte = HWDATA_I[7:0];

  wire wr_otgcon  = wr_now & (dph_addr_q == `UOP_OFF_OTGCON);
  wire wr_pwrc    = wr_now & (dph_addr_q == `UOP_OFF_PWRC);
  wire wr_irqf    = wr_now & (dph_addr_q == `UOP_OFF_IRQF);
  wire wr_errstat = wr_now & (dph_addr_q == `UOP_OFF_ERRSTAT);
  wire wr_erren   = wr_now & (dph_addr_q == `UOP_OFF_ERREN);

  // zero wait states, always okay
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = 1'b0;
  assign HRDATA_O    = rdata_q;

  // ---------------------------------------------------------------- timers
  uop_tmr_if tmr_lstable ();
  uop_tmr_if tmr_resume ();
  uop_tmr_if tmr_idle ();

  // any change of the d+ or d- level restarts the stability window
  assign tmr_lstable.restart = line_chg | ~enable_w;
  assign tmr_resume.restart  = ~line_k | ~enable_w;
  assign tmr_idle.restart    = ~line_j | ~enable_w;

  uop_persist #(.LIMIT(LSTABLE_CYCLES)) u_lstable (
    .clk_i   (CLK_I),
    .rst_b_i (RST_B_I),
    .tmr     (tmr_lstable.timer)
  );

  uop_persist #(.LIMIT(RESUME_CYCLES)) u_resume (
    .clk_i   (CLK_I),
    .rst_b_i (RST_B_I),
    .tmr     (tmr_resume.timer)
  );

  uop_persist #(.LIMIT(IDLE_CYCLES)) u_idle (
    .clk_i   (CLK_I),
    .rst_b_i (RST_B_I),
    .tmr     (tmr_idle.timer)
  );

  // flags take only the first cycle of a persisting state
  wire resume_ev = tmr_resume.hit & ~resume_hit_q;
  wire idle_ev   = tmr_idle.hit & ~idle_hit_q;

  // ---------------------------------------------------------------- status word
  uop_byte_t status_w;
  assign status_w[`UOP_ST_ID]      = id_s;
  assign status_w[6]               = 1'b0;
  assign status_w[`UOP_ST_LSTABLE] = tmr_lstable.hit;
  assign status_w[4]               = 1'b0;
  assign status_w[`UOP_ST_SESSV]   = vbus_s;
  // a low identity level marks the A role, a high one the B role
  assign status_w[`UOP_ST_BSEND]   = id_s & ~vbus_s;
  assign status_w[1]               = 1'b0;
  assign status_w[`UOP_ST_AVBUS]   = ~id_s & vbus_s;

  // ---------------------------------------------------------------- next values
  assign otgcon_d = wr_otgcon ? (wbyte & `UOP_OC_MASK) : otgcon_q;

  assign pwrc_d = wr_pwrc ? (wbyte & `UOP_PC_WMASK) : pwrc_q;

  // error sources latch only while the block is on, regardless of their enable bits; only enabled ones reach the summary
  assign errstat_d = (ERROR_EV_I & {8{enable_w}})
                   | (errstat_q & ~(wr_errstat ? wbyte : `UOP_RESET_BYTE));
  assign erren_d   = wr_erren ? wbyte : erren_q;

  // hardware set wins over a write-one clear in the same cycle
  uop_byte_t irq_set;
  uop_byte_t irq_clr;
  assign irq_set[`UOP_IF_STALL]  = STALL_EV_I;
  assign irq_set[`UOP_IF_ATTACH] = ATTACH_EV_I;
  assign irq_set[`UOP_IF_RESUME] = resume_ev;
  assign irq_set[`UOP_IF_IDLE]   = idle_ev;
  assign irq_set[`UOP_IF_TOKEN]  = TOKEN_DONE_EV_I;
  assign irq_set[`UOP_IF_SOF]    = FRAME_START_EV_I;
  assign irq_set[`UOP_IF_ERROR]  = 1'b0;
  assign irq_set[`UOP_IF_RESET]  = BUS_RESET_EV_I;
  assign irq_clr = wr_irqf ? (wbyte & `UOP_IF_W1C_MASK) : `UOP_RESET_BYTE;

  wire err_summary = |(errstat_d & erren_d);

  always_comb begin
    irqf_d = ((irq_set & {8{enable_w}}) | (irqf_q & ~irq_clr));
    irqf_d[`UOP_IF_ERROR] = err_summary;
  end

  // a clear of a set token-done flag moves the token fifo on
  wire token_clear = irq_clr[`UOP_IF_TOKEN] & irqf_q[`UOP_IF_TOKEN];

  // activity is latched until the notification is taken, set wins over ack
  assign act_pend_d = (enable_w & any_chg) | (act_pend_q & ~ACTIVITY_ACK_I);

  // ---------------------------------------------------------------- power sequencing
  always_comb begin
    pwr_d   = pwr_q;
    drain_d = drain_q;
    case (pwr_q)
      UOP_PWR_OFF: begin
        if (enable_w) begin
          pwr_d = UOP_PWR_ON;
        end
      end
      UOP_PWR_ON: begin
        if (!enable_w) begin
          pwr_d   = UOP_PWR_DRAIN;
          drain_d = `UOP_DRAIN_CYCLES;
        end
      end
      UOP_PWR_DRAIN: begin
        // a re-enable during the drain returns straight to on; otherwise the count runs down to off
        if (enable_w) begin
          pwr_d = UOP_PWR_ON;
        end else if (drain_q == 4'h0) begin
          pwr_d = UOP_PWR_OFF;
        end else begin
          drain_d = drain_q - 4'h1;
        end
      end
      default: begin
        pwr_d   = UOP_PWR_OFF;
        drain_d = 4'h0;
      end
    endcase
  end

  // ---------------------------------------------------------------- read data
  uop_byte_t pwrc_rd;
  uop_byte_t rd_byte;
  always_comb begin
    pwrc_rd                 = pwrc_d & `UOP_PC_WMASK;
    pwrc_rd[`UOP_PC_ACTPND] = act_pend_d;
    pwrc_rd[`UOP_PC_BUSY]   = (pwr_d != UOP_PWR_OFF);
  end

  // read data is taken from next values so a write just ahead is seen
  always_comb begin
    case (HADDR_I[7:0])
      `UOP_OFF_STATUS:  rd_byte = status_w;
      `UOP_OFF_OTGCON:  rd_byte = otgcon_d;
      `UOP_OFF_PWRC:    rd_byte = pwrc_rd;
      `UOP_OFF_IRQF:    rd_byte = irqf_d;
      `UOP_OFF_ERRSTAT: rd_byte = errstat_d;
      `UOP_OFF_ERREN:   rd_byte = erren_d;
      default:          rd_byte = `UOP_RESET_BYTE;
    endcase
  end

  wire rd_hit = addr_take & ~HWRITE_I & (HADDR_I[31:8] == 24'h00_0000);

  // ---------------------------------------------------------------- flip-flops
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      dph_wr_q   <= 1'b0;
      dph_rd_q   <= 1'b0;
      dph_addr_q <= `UOP_RESET_BYTE;
      rdata_q    <= `UOP_ZERO_WORD;
    end else begin
      dph_wr_q   <= addr_take & HWRITE_I & (HADDR_I[31:8] == 24'h00_0000);
      dph_rd_q   <= rd_hit;
      dph_addr_q <= HADDR_I[7:0];
      rdata_q    <= rd_hit ? {24'h00_0000, rd_byte} : `UOP_ZERO_WORD;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      otgcon_q  <= `UOP_RESET_BYTE;
      pwrc_q    <= `UOP_RESET_BYTE;
      erren_q   <= `UOP_RESET_BYTE;
      errstat_q <= `UOP_RESET_BYTE;
      irqf_q    <= `UOP_RESET_BYTE;
    end else begin
      otgcon_q  <= otgcon_d;
      pwrc_q    <= pwrc_d;
      erren_q   <= erren_d;
      errstat_q <= errstat_d;
      irqf_q    <= irqf_d;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      act_pend_q   <= 1'b0;
      resume_hit_q <= 1'b0;
      idle_hit_q   <= 1'b0;
      fifo_adv_q   <= 1'b0;
      drain_q      <= 4'h0;
      pwr_q        <= UOP_PWR_OFF;
    end else begin
      act_pend_q   <= act_pend_d;
      resume_hit_q <= tmr_resume.hit;
      idle_hit_q   <= tmr_idle.hit;
      fifo_adv_q   <= token_clear;
      drain_q      <= drain_d;
      pwr_q        <= pwr_d;
    end
  end

  // ---------------------------------------------------------------- pads and power
  // pull requests come from software or from the engine, never both
  wire [3:0] pulls_sel = otgcon_q[`UOP_OC_SWPULL] ?
                         otgcon_q[`UOP_OC_PULLS_HI:`UOP_OC_PULLS_LO] : HW_PULLS_I;
  wire [3:0] pulls_out = pulls_sel & {4{enable_w}};

  assign DPLUS_PULLUP_O    = pulls_out[3];
  assign DMINUS_PULLUP_O   = pulls_out[2];
  assign DPLUS_PULLDOWN_O  = pulls_out[1];
  assign DMINUS_PULLDOWN_O = pulls_out[0];

  assign VBUS_POWER_O     = enable_w & otgcon_q[`UOP_OC_VBUS_POWER_ON];
  assign VBUS_CHARGE_O    = enable_w & otgcon_q[`UOP_OC_CHARGE];
  assign VBUS_DISCHARGE_O = enable_w & otgcon_q[`UOP_OC_DISCHG];

  // suspend stops the 48 mhz clock and parks the transceiver; disable does both
  assign USB_CLK_RUN_O    = enable_w & ~suspend_w;
  assign XCVR_LOW_POWER_O = suspend_w | ~enable_w;
  assign ANALOG_ENABLE_O  = enable_w;
  assign PINS_OWNED_O     = enable_w;

  // guard blocks sleep while lines move or a notification is owed
  assign SLEEP_BLOCK_O = guard_w & (any_chg | act_pend_q);

  assign TOKEN_FIFO_ADVANCE_O = fifo_adv_q;
  assign ACTIVITY_PENDING_O   = act_pend_q;

  // hsize and the read flag are not needed: every access is a full word
  wire unused_ok = &{1'b0, HSIZE_I, dph_rd_q, line_se0, busy_w};
endmodule : uop_top
`default_nettype wire

// *** design/uop_defs.svh ***
// register map, field positions and timing constants of the usb otg power and status block
//
// Operation
// - status bit 7: 1 = no cable or B cable
// - status bit 5: line state unchanged for 1 ms
// - status bit 3: vbus above session valid threshold
// - status bit 2: B device, vbus below threshold
// - status bit 0: A device, vbus above threshold
// - unimplemented bits, bits 31-8 read zero
// - control bits 7-4 enable the four pull resistors
// - pull control bit 2: software or hardware owns pulls
// - control bit 3 powers the vbus line
// - bit 1 charges vbus, bit 0 discharges vbus
// - power bit 7: activity seen, notification not delivered
// - sleep guard bit 4 blocks sleep on activity
// - busy bit 3: active or not yet re-enableable; a re-enable during the drain is still taken at once
// - suspend bit 1 gates usb clock, transceiver low power
// - enable bit 0; off holds pull, vbus, usb clock, analog and pin ownership outputs inactive
// - resume flag after K state for 2.5 us
// - idle flag after 3 ms continuous idle
// - clearing token done advances the token fifo
// - error summary only from enabled error sources
`ifndef UOP_DEFS_SVH
`define UOP_DEFS_SVH

// byte offsets of the registers
`define UOP_OFF_STATUS   8'h00
`define UOP_OFF_OTGCON   8'h04
`define UOP_OFF_PWRC     8'h08
`define UOP_OFF_IRQF     8'h0C
`define UOP_OFF_ERRSTAT  8'h10
`define UOP_OFF_ERREN    8'h14
`define UOP_RESET_BYTE   8'h00
`define UOP_ZERO_WORD    32'h0000_0000

// status fields
`define UOP_ST_ID        7
`define UOP_ST_LSTABLE   5
`define UOP_ST_SESSV     3
`define UOP_ST_BSEND     2
`define UOP_ST_AVBUS     0
// otg control fields
`define UOP_OC_PULLS_HI  7
`define UOP_OC_PULLS_LO  4
`define UOP_OC_VBUS_POWER_ON    3
`define UOP_OC_SWPULL    2
`define UOP_OC_CHARGE    1
`define UOP_OC_DISCHG    0
`define UOP_OC_MASK      8'hFF
// power control fields
`define UOP_PC_ACTPND    7
`define UOP_PC_SLPGRD    4
`define UOP_PC_BUSY      3
`define UOP_PC_SUSPEND   1
`define UOP_PC_ENABLE    0
`define UOP_PC_WMASK     8'h13
// interrupt flag fields
`define UOP_IF_STALL     7
`define UOP_IF_ATTACH    6
`define UOP_IF_RESUME    5
`define UOP_IF_IDLE      4
`define UOP_IF_TOKEN     3
`define UOP_IF_SOF       2
`define UOP_IF_ERROR     1
`define UOP_IF_RESET     0
`define UOP_IF_W1C_MASK  8'hFD

// timing
`define UOP_CLK_NS       25
`define UOP_LSTABLE_NS   1000000
`define UOP_RESUME_NS    2500
`define UOP_IDLE_NS      3000000
`define UOP_TMR_W        18
`define UOP_DRAIN_CYCLES 4'hF

`endif

// *** design/uop_pkg.sv ***
// types shared by the usb otg power and status block
`default_nettype none
package uop_pkg;
  typedef logic [31:0] uop_word_t;
  typedef logic [7:0]  uop_byte_t;
  // module power sequencing
  typedef enum logic [2:0] {
    UOP_PWR_OFF   = 3'b001,
    UOP_PWR_ON    = 3'b010,
    UOP_PWR_DRAIN = 3'b100
  } uop_pwr_state_t;
endpackage : uop_pkg
`default_nettype wire

// *** design/uop_tmr_if.sv ***
// restart and expiry signals between the block and one persistence timer
`default_nettype none
interface uop_tmr_if;
  logic restart;
  logic hit;
  modport owner (output restart, input hit);
  modport timer (input restart, output hit);
endinterface : uop_tmr_if
`default_nettype wire

// *** design/uop_persist.sv ***
// persistence timer: hit rises once a condition has held for LIMIT cycles
`include "uop_defs.svh"
`default_nettype none
module uop_persist #(
  parameter logic [`UOP_TMR_W-1:0] LIMIT = 18'h00001
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // control
  uop_tmr_if.timer  tmr
);
  logic [`UOP_TMR_W-1:0] cnt_q;
  logic [`UOP_TMR_W-1:0] cnt_d;
  wire                   at_limit = (cnt_q >= LIMIT);

  // saturates so hit stays high while the condition keeps holding
  assign cnt_d   = tmr.restart ? {`UOP_TMR_W{1'b0}} :
                   at_limit    ? cnt_q : cnt_q + 1'b1;
  assign tmr.hit = at_limit & ~tmr.restart;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= {`UOP_TMR_W{1'b0}};
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule : uop_persist
`default_nettype wire

// *** tb/uop_cable_model.sv ***
// cable partner: identity, vbus and line levels seen by the block
`default_nettype none
module uop_cable_model (
  // requested behaviour
  input  wire logic       id_i,
  input  wire logic       vbus_ext_i,
  input  wire logic [1:0] line_i,
  // device drive
  input  wire logic       pwr_i,
  // cable levels
  output logic            id_o,
  output logic            vbus_o,
  output logic            dp_o,
  output logic            dm_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // a powered bus reads valid whoever sources it
  assign vbus_o = vbus_ext_i | pwr_i;
  assign id_o   = id_i;
  // 0 J, 1 K, otherwise SE0
  assign dp_o   = (line_i == 2'b00);
  assign dm_o   = (line_i == 2'b01);
endmodule : uop_cable_model
`default_nettype wire

// *** tb/uop_top_sva.sv ***
// port assertions of the usb otg power and status block
`include "uop_defs.svh"
`default_nettype none
module uop_top_sva #(
  parameter logic [`UOP_TMR_W-1:0] LSTABLE_CYCLES = 18'h00014,
  parameter logic [`UOP_TMR_W-1:0] IDLE_CYCLES    = 18'h0001E
) (
  // clock, reset and bus
  input wire logic              CLK_I,
  input wire logic              RST_B_I,
  input wire logic              HSEL_I,
  input wire uop_pkg::uop_word_t HADDR_I,
  input wire logic [1:0]        HTRANS_I,
  input wire logic              HWRITE_I,
  input wire uop_pkg::uop_word_t HWDATA_I,
  input wire logic              HREADYOUT_O,
  input wire uop_pkg::uop_word_t HRDATA_O,
  // pads and power
  input wire logic [3:0]        HW_PULLS_I,
  input wire logic              DPLUS_PULLUP_O,
  input wire logic              DMINUS_PULLUP_O,
  input wire logic              DPLUS_PULLDOWN_O,
  input wire logic              DMINUS_PULLDOWN_O,
  input wire logic              VBUS_POWER_O,
  input wire logic              VBUS_CHARGE_O,
  input wire logic              VBUS_DISCHARGE_O,
  input wire logic              USB_CLK_RUN_O,
  input wire logic              XCVR_LOW_POWER_O,
  input wire logic              ANALOG_ENABLE_O,
  input wire logic              PINS_OWNED_O,
  input wire logic              TOKEN_FIFO_ADVANCE_O,
  input wire logic              ACTIVITY_PENDING_O,
  input wire logic              ACTIVITY_ACK_I
);
  timeunit 1ns;
  timeprecision 1ps;
  import uop_pkg::*;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);
  logic      wdp_q;
  uop_byte_t ctl_q;
  wire logic take_w = HSEL_I & HREADYOUT_O & HTRANS_I[1] & (HADDR_I[31:8] == 24'h000000);
  wire logic [3:0] pulls_w = {DPLUS_PULLUP_O, DMINUS_PULLUP_O, DPLUS_PULLDOWN_O,
                              DMINUS_PULLDOWN_O};
  // shadow of the pin control register, written at the end of the data phase
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      wdp_q <= 1'b0;
      ctl_q <= 8'h00;
    end else begin
      wdp_q <= take_w & HWRITE_I & (HADDR_I[7:0] == `UOP_OFF_OTGCON);
      if (wdp_q) ctl_q <= HWDATA_I[7:0];
    end
  end
  a_hi_zero: assert property (HRDATA_O[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_pull_src: assert property (ANALOG_ENABLE_O |->
    pulls_w == (ctl_q[2] ? ctl_q[7:4] : HW_PULLS_I))
    else $error("pull outputs wrong");
  a_vbus_ctl: assert property (ANALOG_ENABLE_O |->
    {VBUS_POWER_O, VBUS_CHARGE_O, VBUS_DISCHARGE_O} == {ctl_q[3], ctl_q[1:0]})
    else $error("vbus outputs wrong");
  a_off_quiet: assert property (!ANALOG_ENABLE_O |-> !VBUS_POWER_O && !VBUS_CHARGE_O &&
    !VBUS_DISCHARGE_O && !USB_CLK_RUN_O && XCVR_LOW_POWER_O)
    else $error("outputs active while off");
  a_pins_owned: assert property (PINS_OWNED_O == ANALOG_ENABLE_O)
    else $error("pin ownership wrong");
  a_xcvr_gate: assert property (XCVR_LOW_POWER_O == !USB_CLK_RUN_O)
    else $error("clock gate and low power disagree");
  a_fifo_once: assert property (TOKEN_FIFO_ADVANCE_O |=> !TOKEN_FIFO_ADVANCE_O)
    else $error("fifo advance too long");
  a_pend_cause: assert property ($rose(ACTIVITY_PENDING_O) |-> $past(ANALOG_ENABLE_O))
    else $error("activity pending while off");
  c_sw_pulls: cover property (ANALOG_ENABLE_O && ctl_q[2]);
  c_fifo: cover property ($rose(TOKEN_FIFO_ADVANCE_O));
  c_ack: cover property (ACTIVITY_PENDING_O && ACTIVITY_ACK_I);
endmodule : uop_top_sva
bind uop_top uop_top_sva #(.LSTABLE_CYCLES(LSTABLE_CYCLES), .IDLE_CYCLES(IDLE_CYCLES)) u_sva (
  .CLK_I(CLK_I), .RST_B_I(RST_B_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I),
  .HWRITE_I(HWRITE_I), .HWDATA_I(HWDATA_I), .HREADYOUT_O(HREADYOUT_O), .HRDATA_O(HRDATA_O),
  .HW_PULLS_I(HW_PULLS_I), .DPLUS_PULLUP_O(DPLUS_PULLUP_O), .DMINUS_PULLUP_O(DMINUS_PULLUP_O),
  .DPLUS_PULLDOWN_O(DPLUS_PULLDOWN_O), .DMINUS_PULLDOWN_O(DMINUS_PULLDOWN_O),
  .VBUS_POWER_O(VBUS_POWER_O), .VBUS_CHARGE_O(VBUS_CHARGE_O),
  .VBUS_DISCHARGE_O(VBUS_DISCHARGE_O), .USB_CLK_RUN_O(USB_CLK_RUN_O),
  .XCVR_LOW_POWER_O(XCVR_LOW_POWER_O), .ANALOG_ENABLE_O(ANALOG_ENABLE_O),
  .PINS_OWNED_O(PINS_OWNED_O), .TOKEN_FIFO_ADVANCE_O(TOKEN_FIFO_ADVANCE_O),
  .ACTIVITY_PENDING_O(ACTIVITY_PENDING_O), .ACTIVITY_ACK_I(ACTIVITY_ACK_I));
`default_nettype wire

// *** tb/tb_usb_otg_power_status_control.sv ***
// self-checking bench for the usb otg power and status block
`default_nettype none
module tb_usb_otg_power_status_control;
  timeunit 1ns;
  timeprecision 1ps;
  import uop_pkg::*;
  // short counts keep the run brief
  localparam logic [17:0] LS_C = 18'h00014;
  localparam logic [17:0] IDL_C = 18'h0001E;
  logic       clk, rst_b, hsel, hwrite, ack, id_c, vb_ext;
  logic [1:0] htrans, line;
  logic [4:0] ev;
  logic [3:0] hw_pulls;
  uop_word_t  haddr, hwdata, r;
  uop_byte_t  err_ev, w;
  wire logic  hready, hresp, id_w, vb_w, dp_w, dm_w, dpu, dmu, dpd, dmd, vpw, vch, vdis;
  wire logic  crun, xlp, aen, pown, slp, tfa, apnd;
  wire uop_word_t hrdata_w;
  int n_fail = 0, checks = 0, tmo = 0, k;
  uop_top #(.LSTABLE_CYCLES(LS_C), .IDLE_CYCLES(IDL_C)) dut_u (
    .CLK_I(clk), .RST_B_I(rst_b), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HREADYOUT_O(hready), .HRESP_O(hresp), .HRDATA_O(hrdata_w), .CABLE_IDENTITY_I(id_w),
    .VBUS_SESSION_VALID_I(vb_w), .DPLUS_I(dp_w), .DMINUS_I(dm_w), .STALL_EV_I(ev[4]),
    .ATTACH_EV_I(ev[3]), .TOKEN_DONE_EV_I(ev[2]), .FRAME_START_EV_I(ev[1]),
    .BUS_RESET_EV_I(ev[0]), .ERROR_EV_I(err_ev), .HW_PULLS_I(hw_pulls),
    .ACTIVITY_ACK_I(ack), .DPLUS_PULLUP_O(dpu), .DMINUS_PULLUP_O(dmu),
    .DPLUS_PULLDOWN_O(dpd), .DMINUS_PULLDOWN_O(dmd), .VBUS_POWER_O(vpw),
    .VBUS_CHARGE_O(vch), .VBUS_DISCHARGE_O(vdis), .USB_CLK_RUN_O(crun),
    .XCVR_LOW_POWER_O(xlp), .ANALOG_ENABLE_O(aen), .PINS_OWNED_O(pown),
    .SLEEP_BLOCK_O(slp), .TOKEN_FIFO_ADVANCE_O(tfa), .ACTIVITY_PENDING_O(apnd));
  uop_cable_model cab_u (.id_i(id_c), .vbus_ext_i(vb_ext), .line_i(line), .pwr_i(vpw),
    .id_o(id_w), .vbus_o(vb_w), .dp_o(dp_w), .dm_o(dm_w));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function automatic uop_word_t st(input logic id, input logic vb);
    return {24'h000000, id, 3'b000, vb, id & ~vb, 1'b0, ~id & vb};
  endfunction : st
  task automatic give_verdict();
    if (n_fail == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input uop_word_t got, input uop_word_t exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // address phase held until hready, then data phase held until hready
  task automatic bus(input logic wr_en, input uop_word_t a, input uop_word_t d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr_en;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    r = hrdata_w;
  endtask : bus
  task automatic wr(input uop_word_t a, input uop_byte_t d);
    bus(1'b1, a, {24'h000000, d});
  endtask : wr
  task automatic rd(input uop_word_t a, input uop_byte_t m, input uop_byte_t e);
    bus(1'b0, a, 32'h0000_0000);
    chk(r & {24'hFFFFFF, m}, {24'h000000, e});
    chk(32'(hresp), 32'h0);
  endtask : rd
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  task automatic fifo_count();
    k = 0;
    repeat (3) begin
      @(posedge clk);
      k += tfa;
    end
  endtask : fifo_count
  always @(posedge clk) begin
    tmo <= tmo + 1;
    if (tmo == 20000) begin
      n_fail++;
      give_verdict();
    end
  end
  initial begin
    {rst_b, hsel, hwrite, ack, vb_ext, htrans, line, ev, hw_pulls} = '0;
    {haddr, hwdata, err_ev} = '0;
    id_c = 1'b1;
    void'($urandom(25122));
    wt(12);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(32'h04, 8'hFF, 8'h00);
    rd(32'h08, 8'hFF, 8'h00);
    rd(32'h0C, 8'hFF, 8'h00);
    rd(32'h104, 8'hFF, 8'h00);
    wr(32'h08, 8'h01);
    wt(2);
    rd(32'h08, 8'hFF, 8'h09);
    for (int i = 0; i < 8; i++) begin
      {id_c, vb_ext} <= (i < 4) ? 2'(i) : 2'($urandom);
      wt(4);
      rd(32'h00, 8'hDF, st(id_c, vb_ext));
    end
    wt(30);
    rd(32'h00, 8'h20, 8'h20);
    line <= 2'b01;
    wt(4);
    rd(32'h00, 8'h20, 8'h00);
    wr(32'h0C, 8'h30);
    wt(60);
    rd(32'h0C, 8'h20, 8'h00);
    wt(50);
    rd(32'h0C, 8'h20, 8'h20);
    line <= 2'b00;
    wr(32'h0C, 8'h10);
    wt(15);
    rd(32'h0C, 8'h10, 8'h00);
    wt(25);
    rd(32'h0C, 8'h10, 8'h10);
    wr(32'h0C, 8'hFD);
    ev <= 5'h1F;
    @(posedge clk);
    ev <= 5'h00;
    rd(32'h0C, 8'hCD, 8'hCD);
    wr(32'h0C, 8'h08);
    fifo_count();
    chk(32'(k), 32'h1);
    rd(32'h0C, 8'hCD, 8'hC5);
    wr(32'h0C, 8'h08);
    fifo_count();
    chk(32'(k), 32'h0);
    err_ev <= 8'h01;
    @(posedge clk);
    err_ev <= 8'h00;
    rd(32'h0C, 8'h02, 8'h00);
    wr(32'h14, 8'h01);
    rd(32'h0C, 8'h02, 8'h02);
    wr(32'h0C, 8'h02);
    rd(32'h0C, 8'h02, 8'h02);
    wr(32'h10, 8'h01);
    rd(32'h0C, 8'h02, 8'h00);
    for (int i = 0; i < 8; i++) begin
      w = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
      hw_pulls <= 4'($urandom);
      wr(32'h04, w);
      rd(32'h04, 8'hFF, w);
      chk({28'h0, dpu, dmu, dpd, dmd}, {28'h0, w[2] ? w[7:4] : hw_pulls});
      chk({29'h0, vpw, vch, vdis}, {29'h0, w[3], w[1:0]});
    end
    wr(32'h04, 8'h00);
    wr(32'h08, 8'h11);
    ack <= 1'b1;
    // a late vbus change may still set pending on the first ack edge
    wt(3);
    ack <= 1'b0;
    wt(2);
    chk({31'h0, apnd, slp}, 32'h0);
    id_c <= ~id_c;
    wt(4);
    chk({31'h0, apnd, slp}, 32'h3);
    rd(32'h08, 8'h80, 8'h80);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    wt(2);
    chk({31'h0, slp}, 32'h0);
    wr(32'h08, 8'h01);
    id_c <= ~id_c;
    wt(4);
    chk({31'h0, apnd, slp}, 32'h2);
    wr(32'h08, 8'h03);
    wt(1);
    chk({31'h0, crun, xlp}, 32'h1);
    wr(32'h08, 8'h01);
    wt(1);
    chk({31'h0, crun, xlp}, 32'h2);
    wr(32'h04, 8'h08);
    wr(32'h08, 8'h00);
    @(posedge clk);
    chk({30'h0, vpw, aen, pown}, 32'h0);
    rd(32'h08, 8'hFF, 8'h88);
    // no access while the drain runs
    wt(20);
    rd(32'h08, 8'hFF, 8'h80);
    give_verdict();
  end
endmodule : tb_usb_otg_power_status_control
`default_nettype wire
